// file: alert_pullup.sv
`timescale 1ns/100ps
// Host side of the alert line
module alert_pullup (
  // Open-drain driver terms
  input logic alert_o,
  input logic alert_oe,
  // Level the host sees
  output logic pin
);
  // Released line is lifted by the pull-up
  assign pin = alert_oe ? alert_o : 1'b1;
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
  import thermal_alarm_pkg::*;
  logic CLK = 1'b0, RESET = 1'b1, CFG_WE = 1'b0, SAMPLE_VALID = 1'b0;
  logic [CFG_W-1:0] CFG_WDATA = 16'h0000, CFG_RDATA;
  logic signed [TEMP_W-1:0] TEMP_VALUE = 13'h0000;
  logic signed [TEMP_W-1:0] UPPER_LIMIT = 13'h0190, LOWER_LIMIT = 13'h0100;
  logic signed [TEMP_W-1:0] CRITICAL_LIMIT_VALUE = 13'h0300;
  logic [2:0] TRIP_STATUS;
  logic SHUTDOWN, ALERT_O, ALERT_OE, pin;
  int err_count = 0, n_compared = 0;
  // Hysteresis in LSBs for each code
  logic [12:0] hysteresis_amount [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
  thermal_alarm_event_logic thermal_alarm_event_logic_i (.*);
  alert_pullup alert_pullup_i (.alert_o(ALERT_O), .alert_oe(ALERT_OE),
    .pin(pin));
  initial forever #2 CLK = ~CLK;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic see(logic [2:0] tr, logic p);
    chk("trip", 16'(tr), 16'(TRIP_STATUS));
    chk("pin", 16'(p), 16'(pin));
  endtask
  // One-cycle strobes; outputs settle two edges on
  task automatic wr(logic [15:0] d);
    @(posedge CLK);
    CFG_WE <= 1'b1;
    CFG_WDATA <= d;
    @(posedge CLK);
    CFG_WE <= 1'b0;
    @(posedge CLK);
    #1;
  endtask
  task automatic smp(logic [12:0] t);
    @(posedge CLK);
    SAMPLE_VALID <= 1'b1;
    TEMP_VALUE <= t;
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    @(posedge CLK);
    #1;
  endtask
  task automatic t_hys;
    logic [15:0] w;
    for (int c = 0; c < 4; c++) begin
      w = {5'h00, 2'(c), 9'h008};
      wr(w);
      chk("cfg", w, CFG_RDATA);
      smp(UPPER_LIMIT + 13'h1); see(3'b010, 1'b0);
      smp(UPPER_LIMIT - hysteresis_amount[c] + 13'h1); see(3'b010, 1'b0);
      smp(UPPER_LIMIT - hysteresis_amount[c]); see(3'b000, 1'b1);
      smp(LOWER_LIMIT - hysteresis_amount[c]); see(3'b000, 1'b1);
      smp(LOWER_LIMIT - hysteresis_amount[c] - 13'h1); see(3'b001, 1'b0);
      smp(LOWER_LIMIT - 13'h1); see(3'b001, 1'b0);
      smp(LOWER_LIMIT); see(3'b000, 1'b1);
    end
    $display("hysteresis test done");
  endtask
  task automatic t_event;
    wr(16'h0009);
    smp(13'h0191); see(3'b010, 1'b0);
    wr(16'h0029); see(3'b010, 1'b1);
    chk("cfg", 16'h0009, CFG_RDATA);
    wr(16'h0028); see(3'b010, 1'b0);
    wr(16'h0009); see(3'b010, 1'b1);
    smp(13'h0300); see(3'b110, 1'b0);
    wr(16'h0029); see(3'b110, 1'b0);
    smp(13'h02ff); see(3'b010, 1'b1);
    wr(16'h000c); see(3'b010, 1'b1);
    smp(13'h0300); see(3'b110, 1'b0);
    wr(16'h002c); see(3'b110, 1'b0);
    wr(16'h000e); see(3'b110, 1'b1);
    smp(13'h02ff); see(3'b010, 1'b0);
    wr(16'h0000); see(3'b010, 1'b1);
    $display("event test done");
  endtask
  task automatic t_shdn_lock;
    wr(16'h0108);
    chk("shdn", 16'h0001, 16'(SHUTDOWN));
    smp(13'h0100); see(3'b010, 1'b1);
    wr(16'h0448);
    chk("shdn", 16'h0000, 16'(SHUTDOWN));
    wr(16'hff61);
    chk("cfg", 16'h0458, CFG_RDATA);
    chk("shdn", 16'h0000, 16'(SHUTDOWN));
    $display("shutdown and lock test done");
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge CLK);
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    #1;
    chk("cfg", 16'h0000, CFG_RDATA);
    chk("pin", 16'h0001, 16'(pin));
    $display("reset test done");
    t_hys;
    t_event;
    t_shdn_lock;
    print_verdict;
  end
endmodule

// file: thermal_alarm_checker_properties.sv
`timescale 1ns/100ps
module thermal_alarm_checker import thermal_alarm_pkg::*; (
  // Clock and reset
  input logic CLK,
  input logic RESET,
  // Config port
  input logic CFG_WE,
  input logic [CFG_W-1:0] CFG_WDATA,
  input logic [CFG_W-1:0] CFG_RDATA,
  // Samples and limits
  input logic SAMPLE_VALID,
  input logic signed [TEMP_W-1:0] TEMP_VALUE,
  input logic signed [TEMP_W-1:0] UPPER_LIMIT,
  input logic signed [TEMP_W-1:0] LOWER_LIMIT,
  input logic signed [TEMP_W-1:0] CRITICAL_LIMIT_VALUE,
  // Status and pin
  input logic [2:0] TRIP_STATUS,
  input logic SHUTDOWN,
  input logic ALERT_O,
  input logic ALERT_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Sample that the block accepts
  sequence s_take;
    SAMPLE_VALID && !SHUTDOWN;
  endsequence
  property p_rsvd; CFG_RDATA[15:11] == 5'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_clr; CFG_RDATA[CLEAR_BIT] == 1'b0; endproperty
  a_clr: assert property (p_clr) else $error("clear bit reads one");
  property p_drain; ALERT_O == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("pin driven high");
  // Locks clear only on reset, so the field must freeze until then
  property p_lock; |CFG_RDATA[7:6] |=> $stable(CFG_RDATA[10:9]); endproperty
  a_lock: assert property (p_lock) else $error("locked field moved");
  property p_crit;
    s_take |=> TRIP_STATUS[2] ==
      ($past(TEMP_VALUE) >= $past(CRITICAL_LIMIT_VALUE));
  endproperty
  a_crit: assert property (p_crit) else $error("critical status");
  property p_above; s_take ##0 TEMP_VALUE > UPPER_LIMIT |=> TRIP_STATUS[1];
  endproperty
  a_above: assert property (p_above) else $error("above not set");
  property p_below;
    s_take ##0 TEMP_VALUE >= LOWER_LIMIT |=> !TRIP_STATUS[0];
  endproperty
  a_below: assert property (p_below) else $error("below not clear");
  property p_frozen; SHUTDOWN |=> $stable(TRIP_STATUS); endproperty
  a_frozen: assert property (p_frozen) else $error("flags moved");
endmodule
bind thermal_alarm_event_logic thermal_alarm_checker checker_i (.*);

// file: thermal_alarm_event_logic.sv
`timescale 1ns/100ps

// How it works
// - Two-bit code picks hysteresis, none after reset
// - Hysteresis applies only on falling temperature
// - Either lock freezes the hysteresis field
// - Reserved bits read zero, writes ignored
// - Clear bit reads zero, inert in comparator
// - Clear write drops pending interrupt alert
// - Enable, mode and polarity bits steer alert
// - Above flag: set over upper, hysteretic clear
// - Below flag: hysteretic set, clears at lower
// - Critical zone forces comparator alert behaviour
// - Shutdown freezes flags and alert state
// - Critical status is temperature at/above critical
// - Asserted pin takes the polarity-selected level
// - Mode zero comparator default, one interrupt
module thermal_alarm_event_logic (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Configuration register port
  input wire logic CFG_WE,
  input wire logic [thermal_alarm_pkg::CFG_W-1:0] CFG_WDATA,
  output logic [thermal_alarm_pkg::CFG_W-1:0] CFG_RDATA,
  // Temperature samples from the sensing unit
  input wire logic SAMPLE_VALID,
  input wire logic signed [thermal_alarm_pkg::TEMP_W-1:0] TEMP_VALUE,
  // Trip limits from the limit registers
  input wire logic signed [thermal_alarm_pkg::TEMP_W-1:0] UPPER_LIMIT,
  input wire logic signed [thermal_alarm_pkg::TEMP_W-1:0] LOWER_LIMIT,
  input wire logic signed [thermal_alarm_pkg::TEMP_W-1:0]
    CRITICAL_LIMIT_VALUE,
  // Trip status bits and shutdown state
  output logic [2:0] TRIP_STATUS,
  output logic SHUTDOWN,
  // Open-drain alert pin
  output logic ALERT_O,
  output logic ALERT_OE
);
  import thermal_alarm_pkg::*;

  // Stored configuration fields
  // Polarity stays writable under lock; only the listed fields freeze
  logic mode_r, mode_nxt;            // Event mode
  logic pol_r, pol_nxt;              // Event polarity
  logic crit_only_r, crit_only_nxt;  // Critical event only
  logic out_en_r, out_en_nxt;        // Event output enable
  logic alarm_lock_r, alarm_lock_nxt;
  logic crit_lock_r, crit_lock_nxt;
  logic shdn_r, shdn_nxt;            // Shutdown
  logic [1:0] hys_r, hys_nxt;        // Hysteresis code

  // Trip flags and alert state
  // Flags only move on an accepted sample
  logic above_r, above_nxt;          // Above alarm window
  logic below_r, below_nxt;          // Below alarm window
  logic crit_r, crit_nxt;            // At or above critical
  logic crit_zone_r, crit_zone_nxt;  // Critical with hysteresis
  logic pend_r, pend_nxt;            // Interrupt pending
  logic alert_r, alert_nxt;          // Alert asserted
  logic [CFG_W-1:0] rdata_r, rdata_nxt;

  // Comparison helpers
  // All compares are signed, one guard bit wide
  logic [EXT_W-1:0] hys_amt;
  logic signed [EXT_W-1:0] t_ext, up_ext, lo_ext, cr_ext;
  logic signed [EXT_W-1:0] up_hys, lo_hys, cr_hys;
  logic locked;       // Either lock set
  logic clear_req;    // Clear-event write in interrupt mode
  logic update;       // Fresh sample while running
  logic event_cond;   // Comparator view of the enabled flags

  // Hysteresis amount decode
  // Amounts are in temperature LSBs, so no scaling in the compare
  // A code change takes effect at the next accepted sample
  always_comb begin
    case (hys_r)
      HYS_NONE: hys_amt = '0;
      HYS_1P5: hys_amt = HYS_1P5_LSB;
      HYS_3P0: hys_amt = HYS_3P0_LSB;
      HYS_6P0: hys_amt = HYS_6P0_LSB;
      default: hys_amt = '0;
    endcase
  end

  // Sign-extend so limit minus hysteresis cannot wrap
  // A limit near the negative end would otherwise flip sign
  // The guard bit costs one adder bit per limit
  always_comb begin
    t_ext = EXT_W'(TEMP_VALUE);
    up_ext = EXT_W'(UPPER_LIMIT);
    lo_ext = EXT_W'(LOWER_LIMIT);
    cr_ext = EXT_W'(CRITICAL_LIMIT_VALUE);
    up_hys = up_ext - $signed(hys_amt);
    lo_hys = lo_ext - $signed(hys_amt);
    cr_hys = cr_ext - $signed(hys_amt);
  end

  // Shared control terms
  // Clear is honoured only in interrupt mode
  // Samples that arrive in shutdown are dropped, not queued
  always_comb begin
    locked = alarm_lock_r | crit_lock_r;
    clear_req = CFG_WE & CFG_WDATA[CLEAR_BIT] & mode_r;
    update = SAMPLE_VALID & ~shdn_r;
  end

  // Configuration next values
  // Write data is taken whole; no byte-wise update
  // Lock checks use the stored lock bits, so a write that sets a lock
  // still lands its own hysteresis and mode fields
  always_comb begin
    mode_nxt = mode_r;
    pol_nxt = pol_r;
    crit_only_nxt = crit_only_r;
    out_en_nxt = out_en_r;
    alarm_lock_nxt = alarm_lock_r;
    crit_lock_nxt = crit_lock_r;
    shdn_nxt = shdn_r;
    hys_nxt = hys_r;
    if (CFG_WE) begin
      // Reserved bits 15:11 are never stored
      if (!locked) begin
        mode_nxt = CFG_WDATA[MODE_BIT];
        out_en_nxt = CFG_WDATA[OUT_EN_BIT];
        hys_nxt = CFG_WDATA[HYS_HI_BIT:HYS_LO_BIT];
      end
      pol_nxt = CFG_WDATA[POL_BIT];
      if (!alarm_lock_r) begin
        crit_only_nxt = CFG_WDATA[CRIT_ONLY_BIT];
      end
      // Locks are sticky until reset; a zero write does not unlock
      alarm_lock_nxt = alarm_lock_r | CFG_WDATA[ALARM_LOCK_BIT];
      crit_lock_nxt = crit_lock_r | CFG_WDATA[CRIT_LOCK_BIT];
      // Shutdown may always be left, but not entered while locked
      if (!CFG_WDATA[SHDN_BIT]) begin
        shdn_nxt = 1'b0;
      end else if (!locked) begin
        shdn_nxt = 1'b1;
      end
    end
  end

  // Configuration registers
  // Every field returns to its power-on value on reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode_r <= MODE_RESET;
      pol_r <= POL_RESET;
      crit_only_r <= CRIT_ONLY_RESET;
      out_en_r <= OUT_EN_RESET;
      alarm_lock_r <= LOCK_RESET;
      crit_lock_r <= LOCK_RESET;
      shdn_r <= SHDN_RESET;
      hys_r <= HYS_RESET;
    end else begin
      mode_r <= mode_nxt;
      pol_r <= pol_nxt;
      crit_only_r <= crit_only_nxt;
      out_en_r <= out_en_nxt;
      alarm_lock_r <= alarm_lock_nxt;
      crit_lock_r <= crit_lock_nxt;
      shdn_r <= shdn_nxt;
      hys_r <= hys_nxt;
    end
  end

  // Trip flag next values; frozen between samples and in shutdown
  // Limits are levels and may change at any time; only a sample
  // re-evaluates the flags, so a limit change waits for new data
  always_comb begin
    above_nxt = above_r;
    below_nxt = below_r;
    crit_nxt = crit_r;
    crit_zone_nxt = crit_zone_r;
    if (update) begin
      // Rising edge uses the bare limit, falling edge the lowered one
      if (t_ext > up_ext) begin
        above_nxt = 1'b1;
      end else if (t_ext <= up_hys) begin
        above_nxt = 1'b0;
      end
      if (t_ext < lo_hys) begin
        below_nxt = 1'b1;
      end else if (t_ext >= lo_ext) begin
        below_nxt = 1'b0;
      end
      // Status bit has no hysteresis
      crit_nxt = (t_ext >= cr_ext);
      // Zone that forces comparator behaviour keeps hysteresis
      if (t_ext >= cr_ext) begin
        crit_zone_nxt = 1'b1;
      end else if (t_ext < cr_hys) begin
        crit_zone_nxt = 1'b0;
      end
    end
  end

  // Comparator view; critical-only masks the window flags
  // Next flag values, so the pin moves with the trip bits
  always_comb begin
    if (crit_only_r) begin
      event_cond = crit_zone_nxt;
    end else begin
      event_cond = above_nxt | below_nxt | crit_zone_nxt;
    end
  end

  // Interrupt pending and alert next values
  // Leaving the critical zone does not pend by itself; the pin falls
  // back to whatever the window events left pending
  always_comb begin
    pend_nxt = pend_r;
    alert_nxt = alert_r;
    // Clear first so that a same-cycle trigger still wins
    if (clear_req) begin
      pend_nxt = 1'b0;
    end
    // Any window crossing in either direction is a new event unless critical-only is set
    if (update && !crit_only_r &&
        ((above_nxt != above_r) || (below_nxt != below_r))) begin
      pend_nxt = 1'b1;
    end
    if (!mode_r) begin
      // Pending is meaningless in comparator mode
      pend_nxt = 1'b0;
    end
    // Shutdown holds the alert register where it was
    if (!shdn_r) begin
      if (!out_en_r) begin
        alert_nxt = 1'b0;
      end else if (!mode_r || crit_zone_nxt) begin
        alert_nxt = event_cond;
      end else begin
        alert_nxt = pend_nxt;
      end
    end
  end

  // Flag and alert registers
  // All flags start clear, so the pin starts inactive
  always_ff @(posedge CLK) begin
    if (RESET) begin
      above_r <= 1'b0;
      below_r <= 1'b0;
      crit_r <= 1'b0;
      crit_zone_r <= 1'b0;
      pend_r <= 1'b0;
      alert_r <= 1'b0;
    end else begin
      above_r <= above_nxt;
      below_r <= below_nxt;
      crit_r <= crit_nxt;
      crit_zone_r <= crit_zone_nxt;
      pend_r <= pend_nxt;
      alert_r <= alert_nxt;
    end
  end

  // Read-back word; clear bit and reserved bits always zero
  // Status mirrors the registered alert, not the pin level
  always_comb begin
    rdata_nxt = '0;
    rdata_nxt[MODE_BIT] = mode_r;
    rdata_nxt[POL_BIT] = pol_r;
    rdata_nxt[CRIT_ONLY_BIT] = crit_only_r;
    rdata_nxt[OUT_EN_BIT] = out_en_r;
    rdata_nxt[STATUS_BIT] = alert_r;
    rdata_nxt[ALARM_LOCK_BIT] = alarm_lock_r;
    rdata_nxt[CRIT_LOCK_BIT] = crit_lock_r;
    rdata_nxt[SHDN_BIT] = shdn_r;
    rdata_nxt[HYS_HI_BIT:HYS_LO_BIT] = hys_r;
  end

  // Registered read data, one cycle behind the fields
  // A cycle of latency keeps the read path off the adders
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs
  // Trip bits ignore enable, mode and clear settings
  always_comb begin
    CFG_RDATA = rdata_r;
    TRIP_STATUS = '0;
    TRIP_STATUS[TRIP_BELOW] = below_r;
    TRIP_STATUS[TRIP_ABOVE] = above_r;
    TRIP_STATUS[TRIP_CRIT] = crit_r;
    SHUTDOWN = shdn_r;
    // Open drain can only pull low; active high releases when asserted
    // Either polarity therefore needs the external pull-up
    ALERT_O = 1'b0;
    ALERT_OE = alert_r ^ pol_r;
  end

endmodule

// file: thermal_alarm_pkg.sv
package thermal_alarm_pkg;

  // Word widths
  localparam int CFG_W = 16;   // Configuration word width
  localparam int TEMP_W = 13;  // Signed temperature, 1/16 degree per LSB
  localparam int EXT_W = 14;   // One guard bit for limit minus hysteresis

  // Configuration field positions
  localparam int MODE_BIT = 0;       // Event mode, 1 = interrupt
  localparam int POL_BIT = 1;        // Event polarity, 1 = active high
  localparam int CRIT_ONLY_BIT = 2;  // Critical event only
  localparam int OUT_EN_BIT = 3;     // Event output control
  localparam int STATUS_BIT = 4;     // Event output status, read only
  localparam int CLEAR_BIT = 5;      // Clear event, write only
  localparam int ALARM_LOCK_BIT = 6; // Alarm window lock
  localparam int CRIT_LOCK_BIT = 7;  // Critical trip lock
  localparam int SHDN_BIT = 8;       // Shutdown
  localparam int HYS_LO_BIT = 9;     // Hysteresis field low bit
  localparam int HYS_HI_BIT = 10;    // Hysteresis field high bit

  // Reset values
  localparam logic [1:0] HYS_RESET = 2'h0;  // No hysteresis after power-on
  localparam logic MODE_RESET = 1'b0;       // Comparator mode
  localparam logic POL_RESET = 1'b0;        // Active low
  localparam logic CRIT_ONLY_RESET = 1'b0;
  localparam logic OUT_EN_RESET = 1'b0;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic SHDN_RESET = 1'b0;

  // Hysteresis field codes
  localparam logic [1:0] HYS_NONE = 2'h0;
  localparam logic [1:0] HYS_1P5 = 2'h1;
  localparam logic [1:0] HYS_3P0 = 2'h2;
  localparam logic [1:0] HYS_6P0 = 2'h3;

  // Hysteresis amounts in temperature LSBs (1/16 degree)
  localparam logic [EXT_W-1:0] HYS_1P5_LSB = 14'h0018;  // 1.5 degrees
  localparam logic [EXT_W-1:0] HYS_3P0_LSB = 14'h0030;  // 3 degrees
  localparam logic [EXT_W-1:0] HYS_6P0_LSB = 14'h0060;  // 6 degrees

  // Trip status layout on the trip output
  localparam int TRIP_BELOW = 0;
  localparam int TRIP_ABOVE = 1;
  localparam int TRIP_CRIT = 2;

endpackage
